//--- rtl/flbsc_regs.svh
// register offsets, field positions, command codes and timing counts for
// the lock-bit set controller; included by the controller and its testbench
`ifndef FLBSC_REGS_SVH
`define FLBSC_REGS_SVH
// apb register offsets (byte addresses)
`define FLBSC_CTRL_OFS      12'h000
`define FLBSC_ADDR_OFS      12'h004
`define FLBSC_STAT_OFS      12'h008
`define FLBSC_IRQ_STAT_OFS  12'h00c
`define FLBSC_IRQ_MASK_OFS  12'h010
// control register fields
`define FLBSC_CTRL_GO       0
`define FLBSC_CTRL_MASTER   1
`define FLBSC_CTRL_CLR      2
`define FLBSC_CTRL_ARRAY    3
// status register fields
`define FLBSC_STAT_BUSY     0
`define FLBSC_STAT_ERR      1
// interrupt status fields
`define FLBSC_IRQ_DONE      0
`define FLBSC_IRQ_ERR       1
// operation status word bits
`define FLBSC_SR_READY      7
`define FLBSC_SR_ECL        5
`define FLBSC_SR_PSL        4
`define FLBSC_SR_VPP        3
`define FLBSC_SR_PROT       1
// command codes
`define FLBSC_CMD_SETUP     8'h60
`define FLBSC_CMD_BLOCK     8'h01
`define FLBSC_CMD_MASTER    8'hf1
`define FLBSC_CMD_ARRAY     8'hff
`define FLBSC_CMD_READ_SR   8'h70
`define FLBSC_CMD_CLEAR_SR  8'h50
// bus cycle length in ns and in 8 ns clock cycles, rounded up (write pulse and read access)
`define FLBSC_PULSE_NS      100
`define FLBSC_PULSE_CYC     ((`FLBSC_PULSE_NS + 7) / 8)
`endif

//--- rtl/flbsc_pkg.sv
// types shared by the lock-bit set controller
// assumes nothing of its surroundings
`default_nettype none
package flbsc_pkg;
   // bus sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_WSET  = 7'h02,
      ST_WPUL  = 7'h04,
      ST_WHLD  = 7'h08,
      ST_RSET  = 7'h10,
      ST_RACC  = 7'h20,
      ST_WAIT  = 7'h40
   } flbsc_state_t;
endpackage : flbsc_pkg
`default_nettype wire

//--- rtl/flbsc_ctrl.sv
// host-side controller that sets flash lock bits over the async bus
// assumes an apb master on REF_CLK and a flash whose ready/busy pin is
// sampled synchronously to REF_CLK
`include "flbsc_regs.svh"
`default_nettype none
// Overview of operation
// R1: write 60 then 01 or f1
// R2: busy pin low while engine runs
// R3: pin stays high in suspend or powerdown
// R4: pin usable as completion interrupt
// R5: batch sets, check status once
// R6: write ff to return array read
// R7: both error bits mean bad sequence
// R8: protection bit set on refusal
// R9: set-lock error bit flags failure
// R10: erase/clear error bit flags failure
// R11: error bits sticky until clear-status
// R12: clear status before any retry
// R13: missing high voltage sets bits 1,4
// R14: reads return status after sequence
// R15: bit 0 reserved, ignore it
module flbsc_ctrl
   import flbsc_pkg::*;
#(
   parameter int ADDR_W = 21,
   parameter int PULSE  = `FLBSC_PULSE_CYC
) (
   // clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              NRST,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // interrupt
   output logic                   IRQ,
   // flash pins
   output logic      [ADDR_W-1:0] FL_ADDR,
   input  wire logic [7:0]        FL_DQ_IN,
   output logic      [7:0]        FL_DQ_OUT,
   output logic                   FL_DQ_OE,
   output logic                   FL_CE_N,
   output logic                   FL_OE_N,
   output logic                   FL_WE_N,
   input  wire logic              FL_READY_BUSY
);
   // refuse parameters that the counters and buses cannot hold
   if (ADDR_W < 1 || ADDR_W > 32 || PULSE < 1 || PULSE > 255) begin : g_bad
      $error("flbsc_ctrl: unsupported parameters");
   end

   flbsc_state_t state_ff;              // bus sequencer state
   logic [7:0]   cnt_ff;                // cycle counter in a bus phase
   logic [7:0]   cmd_ff;                // byte being written
   logic [1:0]   step_ff;               // 0 setup,1 confirm,2 poll,3 single
   logic         master_ff;             // master bit target
   logic [ADDR_W-1:0] addr_ff;          // target block address
   logic [7:0]   sr_ff;                 // OR of status words read since clear
   logic         busy_ff;               // operation in progress
   logic         err_ff;                // any error seen since clear
   logic [1:0]   irq_st_ff;             // sticky events
   logic [1:0]   irq_mask_ff;           // interrupt mask
   logic         done_ev;               // operation finished this cycle
   logic         err_ev;                // finished with error
   logic         wr_acc;                // apb write access
   logic         rd_acc;                // apb read access

   // apb access phase qualifiers
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && PENABLE && !PWRITE;

   // error decode of a status word, reserved bit 0 ignored
   function automatic logic sr_error(input logic [7:0] sr);
      // R15 mask reserved bit
      sr_error = sr[`FLBSC_SR_ECL] | sr[`FLBSC_SR_PSL] |
                 sr[`FLBSC_SR_VPP] | sr[`FLBSC_SR_PROT];
   endfunction : sr_error

   // pre-register apb reads, always ready
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         PRDATA  <= 32'h0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         if (PSEL && !PENABLE && !PWRITE) begin
            if (PADDR == `FLBSC_CTRL_OFS) begin
               // control reads back only the stored master choice
               PRDATA <= 32'h0 | 32'(master_ff) << `FLBSC_CTRL_MASTER;
            end else if (PADDR == `FLBSC_ADDR_OFS) begin
               // target address, zero-extended
               PRDATA <= 32'(addr_ff);
            end else if (PADDR == `FLBSC_STAT_OFS) begin
               // R7 R8 R9 R13 status word reported as read
               PRDATA <= {16'h0, sr_ff, 6'h0, err_ff, busy_ff};
            end else if (PADDR == `FLBSC_IRQ_STAT_OFS) begin
               // sticky events
               PRDATA <= {30'h0, irq_st_ff};
            end else if (PADDR == `FLBSC_IRQ_MASK_OFS) begin
               // interrupt mask
               PRDATA <= {30'h0, irq_mask_ff};
            end else begin
               // unmapped reads as zero
               PRDATA <= 32'h0;
            end
         end
      end
   end

   // software-held target and mask
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         addr_ff     <= '0;
         master_ff   <= 1'b0;
         irq_mask_ff <= 2'h0;
      end else if (wr_acc && PREADY) begin
         if (PADDR == `FLBSC_ADDR_OFS) begin
            // target latched for the next sequence
            addr_ff <= PWDATA[ADDR_W-1:0];
         end else if (PADDR == `FLBSC_IRQ_MASK_OFS) begin
            // mask always writable
            irq_mask_ff <= PWDATA[1:0];
         end else if (PADDR == `FLBSC_CTRL_OFS && !busy_ff) begin
            // master choice frozen while a sequence runs
            master_ff <= PWDATA[`FLBSC_CTRL_MASTER];
         end
      end
   end

   // bus sequencer driving flash pins
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= 8'h0;
         cmd_ff    <= 8'h0;
         step_ff   <= 2'h0;
         busy_ff   <= 1'b0;
         sr_ff     <= 8'h0;
         FL_ADDR   <= '0;
         FL_DQ_OUT <= 8'h0;
         FL_DQ_OE  <= 1'b0;
         FL_CE_N   <= 1'b1;
         FL_OE_N   <= 1'b1;
         FL_WE_N   <= 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               // bus idle, strobes released
               FL_CE_N  <= 1'b1;
               FL_OE_N  <= 1'b1;
               FL_WE_N  <= 1'b1;
               FL_DQ_OE <= 1'b0;
               if (wr_acc && PREADY && PADDR == `FLBSC_CTRL_OFS) begin
                  if (PWDATA[`FLBSC_CTRL_GO]) begin
                     // R1 setup code first
                     cmd_ff   <= `FLBSC_CMD_SETUP;
                     step_ff  <= 2'h0;
                     busy_ff  <= 1'b1;
                     state_ff <= ST_WSET;
                  end else if (PWDATA[`FLBSC_CTRL_CLR]) begin
                     // R11 R12 only clear-status resets error bits
                     cmd_ff   <= `FLBSC_CMD_CLEAR_SR;
                     step_ff  <= 2'h3;
                     // single-byte commands hold busy too, so polling works
                     busy_ff  <= 1'b1;
                     sr_ff    <= 8'h0;
                     state_ff <= ST_WSET;
                  end else if (PWDATA[`FLBSC_CTRL_ARRAY]) begin
                     // R6 back to array read
                     cmd_ff   <= `FLBSC_CMD_ARRAY;
                     step_ff  <= 2'h3;
                     busy_ff  <= 1'b1;
                     state_ff <= ST_WSET;
                  end
               end
            end
            ST_WSET: begin
               // address and data set up before the write strobe
               FL_ADDR   <= addr_ff;
               FL_DQ_OUT <= cmd_ff;
               FL_DQ_OE  <= 1'b1;
               FL_CE_N   <= 1'b0;
               cnt_ff    <= 8'(PULSE);
               state_ff  <= ST_WPUL;
            end
            ST_WPUL: begin
               // hold the write strobe low for PULSE cycles
               FL_WE_N <= 1'b0;
               cnt_ff  <= cnt_ff - 8'h1;
               if (cnt_ff == 8'h1) begin
                  state_ff <= ST_WHLD;
               end
            end
            ST_WHLD: begin
               // strobe ends with data still held
               FL_WE_N <= 1'b1;
               if (FL_WE_N) begin
                  FL_CE_N  <= 1'b1;
                  FL_DQ_OE <= 1'b0;
                  if (step_ff == 2'h0) begin
                     // R1 block or master confirm
                     cmd_ff   <= master_ff ? `FLBSC_CMD_MASTER
                                           : `FLBSC_CMD_BLOCK;
                     step_ff  <= 2'h1;
                     state_ff <= ST_WSET;
                  end else if (step_ff == 2'h1) begin
                     // both command bytes out, wait for the engine
                     step_ff  <= 2'h2;
                     state_ff <= ST_WAIT;
                  end else begin
                     // single-byte command done, release busy
                     busy_ff  <= 1'b0;
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_WAIT: begin
               // R2 R4 wait for ready/busy to return high
               if (FL_READY_BUSY) begin
                  state_ff <= ST_RSET;
               end
            end
            ST_RSET: begin
               // R14 a plain read returns the status word
               FL_CE_N  <= 1'b0;
               FL_OE_N  <= 1'b0;
               cnt_ff   <= 8'(PULSE);
               state_ff <= ST_RACC;
            end
            ST_RACC: begin
               cnt_ff <= cnt_ff - 8'h1;
               if (cnt_ff == 8'h1) begin
                  FL_CE_N <= 1'b1;
                  FL_OE_N <= 1'b1;
                  if (FL_DQ_IN[`FLBSC_SR_READY]) begin
                     // R11 accumulate sticky errors, R15 drop bit 0
                     sr_ff    <= sr_ff | {FL_DQ_IN[7:1], 1'b0};
                     busy_ff  <= 1'b0;
                     state_ff <= ST_IDLE;
                  end else begin
                     // R3 pin may read ready in suspend: poll again
                     state_ff <= ST_RSET;
                  end
               end
            end
            default: begin
               // illegal one-hot code recovers to idle
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // completion and error events, one cycle at the last read beat
   assign done_ev = (state_ff == ST_RACC) && (cnt_ff == 8'h1) &&
                    FL_DQ_IN[`FLBSC_SR_READY];
   assign err_ev  = done_ev && sr_error(FL_DQ_IN);

   // R5 error summary over a batch
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         err_ff <= 1'b0;
      end else if (err_ev) begin
         err_ff <= 1'b1;
      end else if (state_ff == ST_IDLE && wr_acc && PREADY &&
                   PADDR == `FLBSC_CTRL_OFS && PWDATA[`FLBSC_CTRL_CLR]) begin
         // cleared with the status word by clear-status
         err_ff <= 1'b0;
      end
   end

   // sticky events, write one to clear, set wins
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_st_ff <= 2'h0;
      end else begin
         if (wr_acc && PREADY && PADDR == `FLBSC_IRQ_STAT_OFS) begin
            // write one to clear, a new event still sets
            irq_st_ff <= (irq_st_ff & ~PWDATA[1:0]) | {err_ev, done_ev};
         end else begin
            irq_st_ff <= irq_st_ff | {err_ev, done_ev};
         end
      end
   end

   // level interrupt
   // registered so the pin comes straight from a flop
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_st_ff & irq_mask_ff);
      end
   end
endmodule : flbsc_ctrl
`default_nettype wire

//--- verif/flbsc_flash_model.sv
// behavioural flash device for the lock-bit controller bench
// assumes the controller drives strobes synchronously to clk
`default_nettype none
module flbsc_flash_model (
   // clock
   input  wire logic       clk,
   // bench controls
   input  wire logic       prot,  // refuse lock-bit sets
   input  wire logic       slow,  // long internal algorithm
   // flash pins
   input  wire logic [7:0] dq_o,
   input  wire logic       ce_n,
   input  wire logic       oe_n,
   input  wire logic       we_n,
   output logic      [7:0] dq_i,
   output logic            rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] stw_ff = 0;  // status word error bits
   logic [7:0] prv_ff = 0;  // previous command byte
   int         bsy_ff = 0;  // cycles left in the algorithm
   logic       tog_ff = 0;  // pattern on an undriven bus
   assign rdy = (bsy_ff == 0);
   assign dq_i = (!ce_n && !oe_n) ? {rdy, stw_ff[6:1], 1'b0} : {8{tog_ff}};
   // algorithm timer and bus pattern
   always @(posedge clk) begin
      tog_ff <= !tog_ff;
      if (bsy_ff != 0)
         bsy_ff <= bsy_ff - 1;
   end
   always @(posedge we_n) if (!ce_n) begin
      prv_ff <= dq_o;
      if (dq_o == 8'h50)
         stw_ff <= 0;
      else if (prv_ff == 8'h60 && (dq_o == 8'h01 || dq_o == 8'hf1)) begin
         bsy_ff <= slow ? 40 : 3;
         if (prot)
            stw_ff <= stw_ff | 8'h12;
      end else if (prv_ff == 8'h60)
         stw_ff <= stw_ff | 8'h30;
   end
endmodule : flbsc_flash_model
`default_nettype wire

//--- verif/flbsc_ctrl_sva.sv
// assertions on the controller's apb and flash pins
// assumes it is bound to the controller's top module
`default_nettype none
module flbsc_ctrl_sva #(parameter int ADDR_W = 21) (
   input wire logic              REF_CLK,
   input wire logic              NRST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   input wire logic [ADDR_W-1:0] FL_ADDR,
   input wire logic [7:0]        FL_DQ_OUT,
   input wire logic              FL_DQ_OE,
   input wire logic              FL_CE_N,
   input wire logic              FL_OE_N,
   input wire logic              FL_WE_N
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY && PENABLE)
      else $error("no ready in access cycle");
   chk_ready_pulse: assert property (PREADY |=> !PREADY && !PSLVERR)
      else $error("ready longer than one cycle");
   chk_strobe_select: assert property (
      !FL_WE_N |-> !FL_CE_N && FL_DQ_OE && FL_OE_N)
      else $error("write strobe without select or data");
   chk_write_stable: assert property (
      !FL_WE_N && $past(!FL_WE_N) |-> $stable(FL_DQ_OUT) && $stable(FL_ADDR))
      else $error("write data moved under strobe");
   chk_read_release: assert property (!FL_OE_N |-> !FL_DQ_OE && !FL_CE_N)
      else $error("read while driving data");
   chk_confirm_follows: assert property (
      $rose(FL_WE_N) && FL_DQ_OUT == 8'h60 |->
      ##[1:60] (!FL_WE_N && FL_DQ_OUT inside {8'h01, 8'hf1}))
      else $error("setup not followed by confirm");
endmodule : flbsc_ctrl_sva
bind flbsc_ctrl flbsc_ctrl_sva #(.ADDR_W(ADDR_W)) flbsc_ctrl_sva_inst (
   .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR),
   .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
   .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));
`default_nettype wire

//--- verif/flbsc_ctrl_tb.sv
// self-checking bench: controller against a behavioural flash
// assumes the apb slave answers within 63 access cycles
`include "flbsc_regs.svh"
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module flbsc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, IRQ, PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_OE_N;
   logic        NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, prot = 0;
   logic        slow = 0, FL_WE_N, FL_READY_BUSY;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, seed = 32'hd94c;
   logic [20:0] FL_ADDR, exp_addr;
   logic [7:0]  FL_DQ_IN, FL_DQ_OUT;
   logic [7:0]  q_wr[$];  // expected flash command bytes
   logic [63:0] q_rd[$];  // expected read data with mask
   logic [11:0] ofs[4] = '{12'h008, 12'h00c, 12'h010, 12'h014};
   int          n_mismatch = 0, compares = 0;
   flbsc_ctrl #(.ADDR_W(21), .PULSE(2)) flbsc_ctrl_inst (
      .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .FL_ADDR(FL_ADDR),
      .FL_DQ_IN(FL_DQ_IN), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE),
      .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
      .FL_READY_BUSY(FL_READY_BUSY));
   flbsc_flash_model flbsc_flash_model_inst (.clk(REF_CLK), .prot(prot),
      .slow(slow), .dq_o(FL_DQ_OUT), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
      .we_n(FL_WE_N), .dq_i(FL_DQ_IN), .rdy(FL_READY_BUSY));
   // 125 MHz clock
   initial begin
      REF_CLK = 0;
      forever #4 REF_CLK = !REF_CLK;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 64);
      r = PRDATA;
      PSEL <= 0;
      PENABLE <= 0;
      if (n >= 64) begin
         n_mismatch++;
         end_of_test();
      end
      @(posedge REF_CLK);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1, a, d, r);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
      logic [31:0] r;
      q_rd.push_back({m, e});
      apb(0, a, 0, r);
   endtask : rd
   // poll the busy flag with a bound
   task automatic wait_idle();
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         apb(0, `FLBSC_STAT_OFS, 0, r);
         n++;
      end while (r[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : wait_idle
   // one lock-bit set; a second go while busy must be ignored
   task automatic lock(input logic m, input logic [7:0] st);
      logic [31:0] r;
      r = rnd();
      exp_addr = r[20:0];
      wr(`FLBSC_ADDR_OFS, {11'h0, exp_addr});
      q_wr.push_back(8'h60);
      q_wr.push_back(m ? 8'hf1 : 8'h01);
      wr(`FLBSC_CTRL_OFS, {30'h0, m, 1'b1});
      wr(`FLBSC_CTRL_OFS, 32'h1);
      wait_idle();
      rd(`FLBSC_STAT_OFS, {16'h0, st, 6'h0, |(st & 8'h3a), 1'b0}, 32'hffff);
      rd(`FLBSC_ADDR_OFS, {11'h0, exp_addr}, 32'h1fffff);
      rd(`FLBSC_CTRL_OFS, {30'h0, m, 1'b0}, 32'hffffffff);
   endtask : lock
   task automatic irq(input logic e);
      @(negedge REF_CLK);
      `CHK("irq", e, IRQ)
      @(posedge REF_CLK);
   endtask : irq
   // read results against the oldest note
   always @(posedge REF_CLK) if (PSEL && PENABLE && PREADY === 1'b1 &&
                                 !PWRITE && q_rd.size() > 0) begin
      `CHK("prdata", q_rd[0][31:0], PRDATA & q_rd[0][63:32])
      void'(q_rd.pop_front());
   end
   // flash command bytes against the oldest note
   always @(negedge FL_WE_N) begin
      `CHK("write expected", 1'b1, q_wr.size() > 0)
      if (q_wr.size() > 0) begin
         `CHK("flash data", q_wr[0], FL_DQ_OUT)
         if (FL_DQ_OUT inside {8'h60, 8'h01, 8'hf1})
            `CHK("flash addr", exp_addr, FL_ADDR)
         void'(q_wr.pop_front());
      end
   end
   initial begin
      #800000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge REF_CLK);
      NRST <= 1;
      @(posedge REF_CLK);
      foreach (ofs[i]) rd(ofs[i], 0, 32'hffffffff);
      wr(`FLBSC_IRQ_MASK_OFS, 3);
      rd(`FLBSC_IRQ_MASK_OFS, 3, 3);
      lock(0, 8'h80);
      irq(1);
      rd(`FLBSC_IRQ_STAT_OFS, 1, 3);
      wr(`FLBSC_IRQ_STAT_OFS, 3);
      irq(0);
      prot <= 1;
      slow <= 1;
      lock(1, 8'h92);
      rd(`FLBSC_IRQ_STAT_OFS, 3, 3);
      wr(`FLBSC_IRQ_STAT_OFS, 3);
      prot <= 0;
      slow <= 0;
      lock(0, 8'h92);
      q_wr.push_back(8'h50);
      wr(`FLBSC_CTRL_OFS, 4);
      wait_idle();
      wr(`FLBSC_IRQ_MASK_OFS, 0);
      lock(0, 8'h80);
      irq(0);
      wr(`FLBSC_IRQ_MASK_OFS, 1);
      irq(1);
      q_wr.push_back(8'hff);
      wr(`FLBSC_CTRL_OFS, 8);
      wait_idle();
      repeat (10) @(posedge REF_CLK);
      `CHK("writes left", 0, q_wr.size())
      end_of_test();
   end
endmodule : flbsc_ctrl_tb
`default_nettype wire
